// ### hw/ssc_pkg.sv
// Shared constants for the synchronous SRAM link and its controller.
// Assumes one clock, pclk, on both ends of the link.
package ssc_pkg;

  ////////////////////////////////////////////////////////////////
  // Link geometry
  localparam int SSC_LANES  = 4;
  localparam int SSC_BYTE_W = 8;
  localparam int SSC_DATA_W = 32;
  localparam int SSC_DQ_W   = 36;
  localparam int SSC_ADDR_W = 10;
  localparam int SSC_DEPTH  = 1024;
  localparam int SSC_BEATS  = 4;
  localparam int SSC_PIPE   = 3;

  // Extra bits undriven and dropped in the narrow mode
  localparam logic [SSC_DQ_W-1:0] SSC_OE_X32   = 36'hf_0000_0000;
  localparam logic [SSC_DQ_W-1:0] SSC_KEEP_X32 = 36'h0_ffff_ffff;
  localparam logic [SSC_LANES-1:0] SSC_BW_NONE = 4'hf;

  ////////////////////////////////////////////////////////////////
  // APB register map
  localparam int SSC_PADDR_W = 8;
  localparam logic [7:0] SSC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] SSC_OFF_ADDR  = 8'h04;
  localparam logic [7:0] SSC_OFF_CMD   = 8'h08;
  localparam logic [7:0] SSC_OFF_STAT  = 8'h0c;
  localparam logic [7:0] SSC_OFF_DATA0 = 8'h10;
  localparam logic [7:0] SSC_OFF_EXTRA = 8'h20;

  // Field positions
  localparam int SSC_CTRL_ORDER  = 0;
  localparam int SSC_CTRL_HOLD   = 1;
  localparam int SSC_CMD_WR      = 0;
  localparam int SSC_CMD_LEN_LSB = 2;
  localparam int SSC_CMD_BE_LSB  = 4;
  localparam int SSC_STAT_BUSY   = 0;

  // Values after reset
  localparam logic [1:0] SSC_CTRL_RST = 2'h1;

  typedef enum logic [2:0] {
    SSC_ST_IDLE  = 3'h1,
    SSC_ST_ISSUE = 3'h2,
    SSC_ST_DRAIN = 3'h4
  } ssc_state_t;

endpackage

// ### hw/ssc_link_if.sv
// Pin-level link between the SRAM end and the controller end.
// Resolves the shared data wires from the two output enables.
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  import ssc_pkg::*;

  logic                  advance_load_ctrl;
  logic                  rd_wr_n;
  logic                  clk_enable_n;
  logic                  burst_order_select;
  logic [SSC_LANES-1:0]  byte_write_en_n;
  logic [SSC_ADDR_W-1:0] addr;
  logic [SSC_DQ_W-1:0]   dev_dq_o;
  logic [SSC_DQ_W-1:0]   dev_oe_n;
  logic [SSC_DQ_W-1:0]   ctl_dq_o;
  logic                  ctl_oe_n;
  logic [SSC_DQ_W-1:0]   dq;
  logic [7:0]            data_lane_a;
  logic [7:0]            data_lane_b;
  logic [7:0]            data_lane_c;
  logic [7:0]            data_lane_d;
  logic [3:0]            extra_bit_lane;

  // Undriven wires float high
  assign dq = (~dev_oe_n & dev_dq_o) | (dev_oe_n & (ctl_oe_n ? '1 : ctl_dq_o));
  assign data_lane_a    = dq[7:0];
  assign data_lane_b    = dq[15:8];
  assign data_lane_c    = dq[23:16];
  assign data_lane_d    = dq[31:24];
  assign extra_bit_lane = dq[35:32];

  modport dev (
    input  pclk, presetn, advance_load_ctrl, rd_wr_n, clk_enable_n,
    input  burst_order_select, byte_write_en_n, addr, dq,
    output dev_dq_o, dev_oe_n
  );
  modport ctl (
    input  pclk, presetn, dq,
    output advance_load_ctrl, rd_wr_n, clk_enable_n, burst_order_select,
    output byte_write_en_n, addr, ctl_dq_o, ctl_oe_n
  );
endinterface
`default_nettype wire

// ### hw/ssc_burst_ctr.sv
// Two-bit burst sequencer for the SRAM end.
// Assumes load and adv are already qualified by the clock enable.
`timescale 1ns/1ps
`default_nettype none
module ssc_burst_ctr (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       load,
  input  wire logic       adv,
  input  wire logic [1:0] start,
  input  wire logic       linear,
  // Next beat index
  output logic [1:0]      nxt_idx
);
  import ssc_pkg::*;

  logic [1:0] start_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_inc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 2'h0;
      cnt_r   <= 2'h0;
    end else if (load) begin
      start_r <= start;
      cnt_r   <= 2'h0;
    end else if (adv) begin
      cnt_r   <= cnt_inc;
    end
  end

  assign cnt_inc = cnt_r + 2'h1;

  assign nxt_idx = linear ? (start_r + cnt_inc) : (start_r ^ cnt_inc);
endmodule
`default_nettype wire

// ### hw/ssc_sram_dev.sv
// SRAM end of the link: cycle type, burst order, byte lanes, storage.
// Assumes the controller drives every link input from pclk flops.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module ssc_sram_dev (
  // Link
  ssc_link_if.dev link,
  // Strap: high for the wide mode
  input wire logic cfg_wide36
);
  import ssc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Declarations
  logic                  run;
  logic                  load;
  logic                  adv;
  logic                  cyc_wr;
  logic [1:0]            nxt_idx;
  logic [SSC_ADDR_W-1:0] beat_addr;
  logic [SSC_DQ_W-1:0]   keep;

  logic                  active_r;
  logic                  dir_wr_r;
  logic [SSC_ADDR_W-3:0] base_r;

  logic                  s1_v_r;
  logic                  s1_wr_r;
  logic [SSC_ADDR_W-1:0] s1_addr_r;
  logic [SSC_LANES-1:0]  s1_be_r;

  logic                  s2_v_r;
  logic                  s2_wr_r;
  logic [SSC_ADDR_W-1:0] s2_addr_r;
  logic [SSC_LANES-1:0]  s2_be_r;

  logic [SSC_DQ_W-1:0]   mem [SSC_DEPTH];
  logic [SSC_DQ_W-1:0]   dout_r;
  logic [SSC_DQ_W-1:0]   oe_n_r;

  logic                  wide_meta_r;
  logic                  wide_r;

  ////////////////////////////////////////////////////////////////
  // Width strap: two flops before any logic reads it
  // The strap is meant to be static; the flops only keep a late
  // change from reaching the lane logic half settled
  // Narrow until the strap has passed both flops after reset
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      wide_meta_r <= 1'b0;
      wide_r      <= 1'b0;
    end else begin
      wide_meta_r <= cfg_wide36;
      wide_r      <= wide_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Lane mask for the configured width
  function automatic logic [SSC_DQ_W-1:0] lane_keep(input logic wide);
    lane_keep = wide ? '1 : SSC_KEEP_X32;
  endfunction

  // Mask follows the synchronised strap only
  assign keep = lane_keep(wide_r);

  ////////////////////////////////////////////////////////////////
  // Control decode

  assign run = ~link.clk_enable_n;

  assign load = run & ~link.advance_load_ctrl;

  assign adv = run & link.advance_load_ctrl & active_r;

  assign cyc_wr = load ? ~link.rd_wr_n : dir_wr_r;

  ////////////////////////////////////////////////////////////////
  // Burst state held between loads
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      active_r <= 1'b0;
      dir_wr_r <= 1'b0;
      base_r   <= '0;
    end else if (load) begin
      active_r <= 1'b1;
      dir_wr_r <= ~link.rd_wr_n;
      base_r   <= link.addr[SSC_ADDR_W-1:2];
    end
  end

  ssc_burst_ctr u_burst (
    .pclk    (link.pclk),
    .presetn (link.presetn),
    .load    (load),
    .adv     (adv),
    .start   (link.addr[1:0]),
    .linear  (~link.burst_order_select),
    .nxt_idx (nxt_idx)
  );

  // Counter wraps inside the aligned group of four
  assign beat_addr = load ? link.addr : {base_r, nxt_idx};

  ////////////////////////////////////////////////////////////////
  // First pipeline stage: address and controls
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      s1_v_r    <= 1'b0;
      s1_wr_r   <= 1'b0;
      s1_addr_r <= '0;
      s1_be_r   <= '0;
    end else if (run) begin
      s1_v_r    <= load | adv;
      s1_wr_r   <= cyc_wr;
      s1_addr_r <= beat_addr;
      s1_be_r   <= cyc_wr ? ~link.byte_write_en_n : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Second pipeline stage: data slot follows one cycle later
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      s2_v_r    <= 1'b0;
      s2_wr_r   <= 1'b0;
      s2_addr_r <= '0;
      s2_be_r   <= '0;
    end else if (run) begin
      s2_v_r    <= s1_v_r;
      s2_wr_r   <= s1_wr_r;
      s2_addr_r <= s1_addr_r;
      s2_be_r   <= s1_be_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Array write; storage keeps no reset
  always_ff @(posedge link.pclk) begin
    if (run && s2_v_r && s2_wr_r) begin
      for (int l = 0; l < SSC_LANES; l++) begin
        if (s2_be_r[l]) begin
          mem[s2_addr_r][l*SSC_BYTE_W +: SSC_BYTE_W] <=
            link.dq[l*SSC_BYTE_W +: SSC_BYTE_W];
          mem[s2_addr_r][SSC_DATA_W + l] <=
            link.dq[SSC_DATA_W + l] & keep[SSC_DATA_W + l];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read output register; drives one cycle per beat so a
  // following write slot finds the wires free
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      dout_r <= '0;
      oe_n_r <= '1;
    end else if (run) begin
      if (s2_v_r && !s2_wr_r) begin
        dout_r <= mem[s2_addr_r] & keep;
        oe_n_r <= wide_r ? '0 : SSC_OE_X32;
      end else begin
        oe_n_r <= '1;
      end
    end
  end

  assign link.dev_dq_o = dout_r;
  assign link.dev_oe_n = oe_n_r;

endmodule
`default_nettype wire

// ### hw/ssc_sram_ctl.sv
// Controller end: APB registers order bursts on the SRAM link.
// Assumes the SRAM end shares pclk and answers with two-cycle latency.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ssc_sram_ctl (
  // Link
  ssc_link_if.ctl link,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ssc_pkg::SSC_PADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr
);
  import ssc_pkg::*;

  ssc_state_t            state_r;
  logic [1:0]            ctrl_r;
  logic [SSC_ADDR_W-1:0] addr_r;
  logic                  cmd_wr_r;
  logic [1:0]            len_r;
  logic [SSC_LANES-1:0]  be_r;
  logic [SSC_DQ_W-1:0]   buf_r [SSC_BEATS];
  logic [1:0]            beat_r;
  logic                  cmd_v_r;
  logic [SSC_PIPE:1]     p_v_r;
  logic [1:0]            p_b_r [1:SSC_PIPE];
  logic                  setup;
  logic                  wr_acc;
  logic                  idle;
  logic                  start;
  logic                  data_hit;
  logic [31:0]           rd_val;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == SSC_OFF_CTRL) || (a == SSC_OFF_ADDR) || (a == SSC_OFF_CMD) ||
             (a == SSC_OFF_STAT) || (a == SSC_OFF_EXTRA) ||
             (a[7:4] == SSC_OFF_DATA0[7:4] && a[1:0] == 2'h0);
  endfunction

  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & pready & mapped(paddr);
  assign idle     = (state_r == SSC_ST_IDLE);
  assign data_hit = (paddr[7:4] == SSC_OFF_DATA0[7:4]);
  // Orders refused while busy or while the SRAM clock is held
  assign start    = wr_acc & idle & ~ctrl_r[SSC_CTRL_HOLD] & (paddr == SSC_OFF_CMD);

  ////////////////////////////////////////////////////////////////
  // APB answer, zero wait states
  always_comb begin
    rd_val = 32'h0;
    case (paddr)
      SSC_OFF_CTRL:  rd_val = 32'(ctrl_r);
      SSC_OFF_ADDR:  rd_val = 32'(addr_r);
      SSC_OFF_CMD:   rd_val = {24'h0, be_r, len_r, 1'b0, cmd_wr_r};
      SSC_OFF_STAT:  rd_val = {31'h0, ~idle};
      SSC_OFF_EXTRA: rd_val = {16'h0, buf_r[3][35:32], buf_r[2][35:32],
                               buf_r[1][35:32], buf_r[0][35:32]};
      default:       rd_val = data_hit ? buf_r[paddr[3:2]][31:0] : 32'h0;
    endcase
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Settings, writable only while idle
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      ctrl_r   <= SSC_CTRL_RST;
      addr_r   <= '0;
      cmd_wr_r <= 1'b0;
      len_r    <= 2'h0;
      be_r     <= '0;
    end else if (wr_acc && idle) begin
      if (paddr == SSC_OFF_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
      if (paddr == SSC_OFF_ADDR) begin
        addr_r <= pwdata[SSC_ADDR_W-1:0];
      end
      if (start) begin
        cmd_wr_r <= pwdata[SSC_CMD_WR];
        len_r    <= pwdata[SSC_CMD_LEN_LSB +: 2];
        be_r     <= pwdata[SSC_CMD_BE_LSB +: SSC_LANES];
      end
    end
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      link.burst_order_select <= SSC_CTRL_RST[SSC_CTRL_ORDER];
      link.clk_enable_n       <= SSC_CTRL_RST[SSC_CTRL_HOLD];
    end else begin
      link.burst_order_select <= ctrl_r[SSC_CTRL_ORDER];
      link.clk_enable_n       <= ctrl_r[SSC_CTRL_HOLD];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Beat buffer: software fills it, read beats overwrite it
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      for (int k = 0; k < SSC_BEATS; k++) begin
        buf_r[k] <= '0;
      end
    end else if (p_v_r[SSC_PIPE] && !cmd_wr_r) begin
      buf_r[p_b_r[SSC_PIPE]] <= link.dq;
    end else if (wr_acc && idle && data_hit) begin
      buf_r[paddr[3:2]][31:0] <= pwdata;
    end else if (wr_acc && idle && paddr == SSC_OFF_EXTRA) begin
      for (int k = 0; k < SSC_BEATS; k++) begin
        buf_r[k][SSC_DATA_W +: 4] <= pwdata[4*k +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Issue sequencer; idle cycles load an empty write
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_r                <= SSC_ST_IDLE;
      beat_r                 <= 2'h0;
      cmd_v_r                <= 1'b0;
      link.advance_load_ctrl <= 1'b0;
      link.rd_wr_n           <= 1'b0;
      link.byte_write_en_n   <= SSC_BW_NONE;
      link.addr              <= '0;
    end else begin
      case (state_r)
        SSC_ST_IDLE: begin
          link.addr <= addr_r;
          if (start) begin
            state_r                <= SSC_ST_ISSUE;
            beat_r                 <= 2'h0;
            cmd_v_r                <= 1'b1;
            link.rd_wr_n           <= ~pwdata[SSC_CMD_WR];
            link.byte_write_en_n   <= pwdata[SSC_CMD_WR] ?
                                      ~pwdata[SSC_CMD_BE_LSB +: SSC_LANES] : SSC_BW_NONE;
          end
        end
        SSC_ST_ISSUE: begin
          if (beat_r == len_r) begin
            state_r                <= SSC_ST_DRAIN;
            cmd_v_r                <= 1'b0;
            link.advance_load_ctrl <= 1'b0;
            link.rd_wr_n           <= 1'b0;
            link.byte_write_en_n   <= SSC_BW_NONE;
          end else begin
            beat_r                 <= beat_r + 2'h1;
            link.advance_load_ctrl <= 1'b1;
          end
        end
        SSC_ST_DRAIN: begin
          if (!cmd_v_r && p_v_r == '0) begin
            state_r <= SSC_ST_IDLE;
          end
        end
        default: state_r <= SSC_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Beat tracking and write data drive
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      p_v_r <= '0;
      for (int i = 1; i <= SSC_PIPE; i++) begin
        p_b_r[i] <= 2'h0;
      end
    end else begin
      p_v_r <= {p_v_r[SSC_PIPE-1:1], cmd_v_r};
      p_b_r[1] <= beat_r;
      for (int i = 2; i <= SSC_PIPE; i++) begin
        p_b_r[i] <= p_b_r[i-1];
      end
    end
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      link.ctl_dq_o <= '0;
      link.ctl_oe_n <= 1'b1;
    end else if (p_v_r[1] && cmd_wr_r) begin
      link.ctl_dq_o <= buf_r[p_b_r[1]];
      link.ctl_oe_n <= 1'b0;
    end else begin
      link.ctl_oe_n <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### bench/ssc_link_props.sv
// Concurrent checks on the link between the SRAM end and the controller.
// Assumes one clock and instantiation beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module ssc_link_props (
  // Clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  // Controller side
  input wire logic                          advance_load_ctrl,
  input wire logic                          rd_wr_n,
  input wire logic                          clk_enable_n,
  input wire logic                          burst_order_select,
  input wire logic [ssc_pkg::SSC_LANES-1:0] byte_write_en_n,
  input wire logic                          ctl_oe_n,
  // Device side
  input wire logic [ssc_pkg::SSC_DQ_W-1:0]  dev_dq_o,
  input wire logic [ssc_pkg::SSC_DQ_W-1:0]  dev_oe_n
);
  import ssc_pkg::*;

  logic last_rd_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////
  // Direction of the latest load; advance beats must follow it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rd_r <= 1'b0;
    end else if (!advance_load_ctrl && !clk_enable_n) begin
      last_rd_r <= rd_wr_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  a_load_dir: assert property (
    (!advance_load_ctrl && !clk_enable_n)
      |-> ##3 (dev_oe_n[31:0] == {32{~$past(rd_wr_n, 3)}}))
    else $error("read drive does not follow load direction");
  a_adv_keeps_dir: assert property (
    (advance_load_ctrl && !clk_enable_n)
      |-> ##3 (dev_oe_n[31:0] == {32{~$past(last_rd_r, 3)}}))
    else $error("advance beat changed direction");
  a_wr_data_slot: assert property (
    (!advance_load_ctrl && !rd_wr_n && !clk_enable_n && byte_write_en_n != 4'hf)
      |-> ##2 !ctl_oe_n)
    else $error("write data not driven two edges after load");
  a_read_no_bw: assert property (
    (!advance_load_ctrl && rd_wr_n) |-> (byte_write_en_n == SSC_BW_NONE))
    else $error("byte enables low on a read load");
  a_order_static: assert property (
    $changed(burst_order_select) |-> (ctl_oe_n && dev_oe_n == '1))
    else $error("burst order changed with traffic on the link");
  a_freeze_holds: assert property (
    clk_enable_n |=> ($stable(dev_oe_n) && $stable(dev_dq_o)))
    else $error("device outputs moved with clock enable high");
  a_no_clash: assert property (
    !ctl_oe_n |-> (dev_oe_n == '1))
    else $error("both ends drive the data wires");
  a_extra_with_word: assert property (
    (dev_oe_n[35:32] != 4'hf) |-> (dev_oe_n[31:0] == 32'h0))
    else $error("extra bits driven without their lanes");
endmodule
`default_nettype wire

// ### bench/sync_sram_cycle_control_tb_top.sv
// Testbench: controller and SRAM end joined by the link, driven over APB.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sync_sram_cycle_control_tb_top;
  import ssc_pkg::*;

  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [SSC_PADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   cfg_wide36;
  logic                   order;
  logic [31:0]            dbuf [4];
  logic [15:0]            xbuf;
  logic [35:0]            mem [int];
  logic [31:0]            q;
  logic [31:0]            r;
  logic                   e;
  int                     seed;
  int                     n_errors;
  int                     n_compared;

  ////////////////////////////////////////////////////////////////
  ssc_link_if ssc_link_if_i (.pclk(pclk), .presetn(presetn));
  ssc_sram_dev ssc_sram_dev_i (.link(ssc_link_if_i.dev), .cfg_wide36(cfg_wide36));
  ssc_sram_ctl ssc_sram_ctl_i (
    .link(ssc_link_if_i.ctl), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ssc_link_props ssc_link_props_i (
    .pclk(ssc_link_if_i.pclk), .presetn(ssc_link_if_i.presetn),
    .advance_load_ctrl(ssc_link_if_i.advance_load_ctrl), .rd_wr_n(ssc_link_if_i.rd_wr_n),
    .clk_enable_n(ssc_link_if_i.clk_enable_n),
    .burst_order_select(ssc_link_if_i.burst_order_select),
    .byte_write_en_n(ssc_link_if_i.byte_write_en_n), .ctl_oe_n(ssc_link_if_i.ctl_oe_n),
    .dev_dq_o(ssc_link_if_i.dev_dq_o), .dev_oe_n(ssc_link_if_i.dev_oe_n));

  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    logic        x;
    int          k;
    k = 0;
    s = 32'h1;
    while (s[SSC_STAT_BUSY] !== 1'b0) begin
      apb(1'b0, SSC_OFF_STAT, 32'h0, s, x);
      k++;
      if (k > 50) begin
        n_errors++;
        test_done();
      end
    end
  endtask

  // Burst through the controller; model kept per word with extra bits on top
  task automatic op(input logic wr, input logic [9:0] a, input logic [1:0] lm1,
                    input logic [3:0] be);
    logic [31:0] d;
    logic [31:0] xr;
    logic        x;
    logic [1:0]  idx;
    int          w;
    if (wr) begin
      for (int n = 0; n < 4; n++) begin
        dbuf[n] = 32'($random(seed));
        apb(1'b1, SSC_OFF_DATA0 + 8'(4 * n), dbuf[n], d, x);
      end
      xbuf = 16'($random(seed));
      apb(1'b1, SSC_OFF_EXTRA, {16'h0, xbuf}, d, x);
    end
    apb(1'b1, SSC_OFF_ADDR, {22'h0, a}, d, x);
    apb(1'b1, SSC_OFF_CMD, {24'h0, (wr ? be : 4'h0), lm1, 1'b0, wr}, d, x);
    wait_idle();
    if (!wr) apb(1'b0, SSC_OFF_EXTRA, 32'h0, xr, x);
    for (int n = 0; n <= int'(lm1); n++) begin
      idx = order ? (a[1:0] ^ 2'(n)) : (a[1:0] + 2'(n));
      w = int'({a[9:2], idx});
      if (wr) begin
        for (int l = 0; l < 4; l++) begin
          if (be[l]) begin
            mem[w][8*l +: 8] = dbuf[n][8*l +: 8];
            mem[w][32+l] = cfg_wide36 ? xbuf[4*n+l] : 1'b0;
          end
        end
      end else begin
        apb(1'b0, SSC_OFF_DATA0 + 8'(4 * n), 32'h0, d, x);
        chk(d, mem[w][31:0]);
        if (cfg_wide36) chk({28'h0, xr[4*n +: 4]}, {28'h0, mem[w][35:32]});
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cfg_wide36 = 1'b1;
    order = 1'b1;
    seed = 32'h7fbb;
    n_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SSC_OFF_CTRL, 32'h0, q, e);
    chk(q, {30'h0, SSC_CTRL_RST});
    apb(1'b1, 8'h24, 32'h5a, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h24, 32'h0, q, e);
    chk(q, 32'h0);
    // Full-width fill so every later read has a known word
    for (int b = 0; b < 4; b++) op(1'b1, {6'h3f, 2'(b), 2'b00}, 2'h3, 4'hf);
    // Mixed bursts, random order, back-to-back directions
    repeat (40) begin
      r = 32'($random(seed));
      order = r[0];
      apb(1'b1, SSC_OFF_CTRL, {31'h0, r[0]}, q, e);
      op(r[1], {6'h3f, r[5:2]}, r[7:6], r[11:8]);
    end
    // Frozen device: command refused, contents kept
    order = 1'b1;
    apb(1'b1, SSC_OFF_CTRL, 32'h3, q, e);
    apb(1'b0, SSC_OFF_CTRL, 32'h0, q, e);
    chk(q, 32'h3);
    apb(1'b1, SSC_OFF_ADDR, 32'h3f0, q, e);
    apb(1'b1, SSC_OFF_CMD, 32'hfd, q, e);
    apb(1'b0, SSC_OFF_STAT, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, SSC_OFF_CTRL, 32'h1, q, e);
    op(1'b0, 10'h3f0, 2'h3, 4'h0);
    // Narrow mode, then wide reads see the extra bits that narrow writes zeroed
    cfg_wide36 <= 1'b0;
    repeat (8) begin
      r = 32'($random(seed));
      op(r[1], {6'h3f, r[5:2]}, r[7:6], r[11:8] | 4'h1);
    end
    cfg_wide36 <= 1'b1;
    for (int b = 0; b < 4; b++) op(1'b0, {6'h3f, 2'(b), 2'b00}, 2'h3, 4'h0);
    test_done();
  end
endmodule
`default_nettype wire
